// ### lsjd_cfg.svh
// Opcode patterns, field positions and cycle costs for the logic/string/jump decoder
`ifndef LSJD_CFG_SVH
`define LSJD_CFG_SVH

// ------------------------------------------------------------
// Opcode patterns and masks
// ------------------------------------------------------------
`define LSJD_OP_XOR_RM 8'h30
`define LSJD_MASK_DW 8'hfc
`define LSJD_OP_XOR_ACC 8'h34
`define LSJD_MASK_W 8'hfe
`define LSJD_OP_MOVE 8'ha4
`define LSJD_OP_COMPARE 8'ha6
`define LSJD_OP_SCAN 8'hae
`define LSJD_OP_LOAD 8'hac
`define LSJD_OP_STORE 8'haa
`define LSJD_OP_PORT_IN 8'h6c
`define LSJD_OP_PORT_OUT 8'h6e
`define LSJD_OP_REPEAT 8'hf2
`define LSJD_OP_JMP_SHORT 8'heb
`define LSJD_OP_JMP_NEAR 8'he9

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LSJD_BIT_W 0
`define LSJD_BIT_D 1
`define LSJD_BIT_Z 0
`define LSJD_MOD_HI 7
`define LSJD_MOD_LO 6
`define LSJD_MOD_REG 2'h3

// ------------------------------------------------------------
// Cycle costs
// ------------------------------------------------------------
`define LSJD_CYC_XOR_REG 8'h03
`define LSJD_CYC_XOR_MEM 8'h0a
`define LSJD_CYC_XOR_ACC_B 8'h03
`define LSJD_CYC_XOR_ACC_W 8'h04
`define LSJD_CYC_MOVE 8'h0e
`define LSJD_CYC_COMPARE 8'h16
`define LSJD_CYC_SCAN 8'h0f
`define LSJD_CYC_LOAD 8'h0c
`define LSJD_CYC_STORE 8'h0a
`define LSJD_CYC_PORT 8'h0e
`define LSJD_CYC_JMP 8'h0e
`define LSJD_REP_MOVE_BASE 8'h08
`define LSJD_REP_MOVE_ITER 8'h08
`define LSJD_REP_CMP_BASE 8'h05
`define LSJD_REP_CMP_ITER 8'h16
`define LSJD_REP_SCAN_BASE 8'h05
`define LSJD_REP_SCAN_ITER 8'h0f
`define LSJD_REP_LOAD_BASE 8'h06
`define LSJD_REP_LOAD_ITER 8'h0b
`define LSJD_REP_STORE_BASE 8'h06
`define LSJD_REP_STORE_ITER 8'h09
`define LSJD_REP_PORT_BASE 8'h08
`define LSJD_REP_PORT_ITER 8'h08
`define LSJD_WORD_PENALTY 8'h04

// Trailing byte counts
`define LSJD_ONE_BYTE 2'h1
`define LSJD_TWO_BYTES 2'h2

`endif

// ### lsjd_pkg.sv
// Types shared by the logic/string/jump decoder modules
package lsjd_pkg;

    // ------------------------------------------------------------
    // Decoded instruction kinds
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        LSJD_K_NONE,
        LSJD_K_XOR_RM,
        LSJD_K_XOR_ACC,
        LSJD_K_MOVE,
        LSJD_K_COMPARE,
        LSJD_K_SCAN,
        LSJD_K_LOAD,
        LSJD_K_STORE,
        LSJD_K_PORT_IN,
        LSJD_K_PORT_OUT,
        LSJD_K_JMP
    } lsjd_kind_t;

    // ------------------------------------------------------------
    // Decoder sequence states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LSJD_S_IDLE,
        LSJD_S_MODRM,
        LSJD_S_TAIL,
        LSJD_S_COST,
        LSJD_S_EXEC
    } lsjd_state_t;

endpackage

// ### lsjd_cost.sv
// Clock-cycle cost calculator for one decoded instruction
`timescale 1ns/1ps
`default_nettype none
`include "lsjd_cfg.svh"

module lsjd_cost
    import lsjd_pkg::*;
#(
    parameter int COUNT_W = 16,
    parameter int CYC_W = 24
) (
    input wire lsjd_kind_t kind,
    input wire logic word,
    input wire logic reg_is_dest,
    input wire logic memory,
    input wire logic repeated,
    input wire logic narrow,
    input wire logic [COUNT_W-1:0] count,
    output logic [CYC_W-1:0] cycles
);

    logic [7:0] single_c; // Cost of the single form
    logic [7:0] rep_base; // Fixed part of the repeated form
    logic [7:0] rep_iter; // Per-iteration part of the repeated form
    logic [1:0] xfers; // Word memory transfers that pay the narrow penalty
    logic [7:0] pen; // Penalty per transfer, zero unless narrow and word
    logic [7:0] iter_total; // Iteration cost including penalty

    // ------------------------------------------------------------
    // Table lookup of the listed costs
    // ------------------------------------------------------------
    always_comb begin
        single_c = `LSJD_CYC_JMP;
        rep_base = 8'h00;
        rep_iter = 8'h00;
        xfers = 2'h0;
        case (kind)
            LSJD_K_XOR_RM: begin
                single_c = memory ? `LSJD_CYC_XOR_MEM : `LSJD_CYC_XOR_REG;
                // Memory destination is read then written back
                xfers = memory ? (reg_is_dest ? 2'h1 : 2'h2) : 2'h0;
            end
            LSJD_K_XOR_ACC: begin
                // Wider immediate costs one more cycle, no bus penalty
                single_c = word ? `LSJD_CYC_XOR_ACC_W : `LSJD_CYC_XOR_ACC_B;
            end
            LSJD_K_MOVE: begin
                single_c = `LSJD_CYC_MOVE;
                rep_base = `LSJD_REP_MOVE_BASE;
                rep_iter = `LSJD_REP_MOVE_ITER;
                xfers = 2'h2;
            end
            LSJD_K_COMPARE: begin
                single_c = `LSJD_CYC_COMPARE;
                rep_base = `LSJD_REP_CMP_BASE;
                rep_iter = `LSJD_REP_CMP_ITER;
                // Repeated compare is listed without the narrow penalty
                xfers = repeated ? 2'h0 : 2'h2;
            end
            LSJD_K_SCAN: begin
                single_c = `LSJD_CYC_SCAN;
                rep_base = `LSJD_REP_SCAN_BASE;
                rep_iter = `LSJD_REP_SCAN_ITER;
                xfers = 2'h1;
            end
            LSJD_K_LOAD: begin
                single_c = `LSJD_CYC_LOAD;
                rep_base = `LSJD_REP_LOAD_BASE;
                rep_iter = `LSJD_REP_LOAD_ITER;
                xfers = 2'h1;
            end
            LSJD_K_STORE: begin
                single_c = `LSJD_CYC_STORE;
                rep_base = `LSJD_REP_STORE_BASE;
                rep_iter = `LSJD_REP_STORE_ITER;
                xfers = 2'h1;
            end
            LSJD_K_PORT_IN: begin
                single_c = `LSJD_CYC_PORT;
                rep_base = `LSJD_REP_PORT_BASE;
                rep_iter = `LSJD_REP_PORT_ITER;
                xfers = repeated ? 2'h1 : 2'h0;
            end
            LSJD_K_PORT_OUT: begin
                single_c = `LSJD_CYC_PORT;
                rep_base = `LSJD_REP_PORT_BASE;
                rep_iter = `LSJD_REP_PORT_ITER;
                // Single form carries no penalty on either variant
                xfers = repeated ? 2'h1 : 2'h0;
            end
            default: begin
                single_c = `LSJD_CYC_JMP;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Penalty and total
    // ------------------------------------------------------------
    always_comb begin
        pen = (narrow && word) ? `LSJD_WORD_PENALTY : 8'h00;
        iter_total = rep_iter + 8'(pen * 8'(xfers));
        if (repeated) begin
            cycles = CYC_W'(rep_base) + CYC_W'(iter_total) * CYC_W'(count);
        end else begin
            cycles = CYC_W'(single_c) + CYC_W'(pen * 8'(xfers));
        end
    end

endmodule
`default_nettype wire

// ### lsjd_decoder.sv
// Opcode decoder and execution timer for xor, string and jump instructions
//
// What this block does
// - Xor forms decode 001100dw and 0011010w, cost 3/10 register/memory, 3/4 accumulator byte/word.
// - Move string 1010010w: 14, repeated 8+8n.
// - Compare string 1010011w: 22, repeated 5+22n.
// - Scan string 1010111w: 15, repeated 5+15n.
// - Load string 1010110w: 12, repeated 6+11n.
// - Store string 1010101w: 10, repeated 6+9n.
// - Port input string 0110110w: 14, repeated 8+8n.
// - Port output string 0110111w: 14 with no word penalty, repeated 8+8n.
// - Repeat prefix iterates count register times.
// - Jumps 11101011/11101001, one or two displacement bytes, 14.
// - Narrow bus adds 4 per word memory transfer, except on repeated compare and single port forms.
`timescale 1ns/1ps
`default_nettype none
`include "lsjd_cfg.svh"

module lsjd_decoder
    import lsjd_pkg::*;
#(
    parameter int COUNT_W = 16,
    parameter int CYC_W = 24
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic BYTE_VALID,
    input wire logic [7:0] BYTE_DATA,
    input wire logic [COUNT_W-1:0] COUNT_REG,
    input wire logic NARROW_BUS,
    output logic BYTE_READY,
    output logic OP_VALID,
    output lsjd_kind_t OP_KIND,
    output logic OP_WORD,
    output logic OP_REG_IS_DEST,
    output logic OP_MEMORY,
    output logic OP_REPEAT,
    output logic OP_REPEAT_COND,
    output logic [CYC_W-1:0] OP_CYCLES,
    output logic OP_UNKNOWN,
    output logic EXEC_BUSY,
    output logic EXEC_DONE
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Worst iteration cost fits in six bits, so the total needs that much headroom
    if (CYC_W < COUNT_W + 6) begin : g_bad_width
        $error("CYC_W too narrow for COUNT_W");
    end
    if (COUNT_W < 1) begin : g_bad_count
        $error("COUNT_W must be positive");
    end

    // ------------------------------------------------------------
    // Opcode classification
    // ------------------------------------------------------------
    function automatic lsjd_kind_t classify(input logic [7:0] op);
        lsjd_kind_t k;
        k = LSJD_K_NONE;
        if ((op & `LSJD_MASK_DW) == `LSJD_OP_XOR_RM) begin
            k = LSJD_K_XOR_RM;
        end else if ((op & `LSJD_MASK_W) == `LSJD_OP_XOR_ACC) begin
            k = LSJD_K_XOR_ACC;
        end else if ((op & `LSJD_MASK_W) == `LSJD_OP_MOVE) begin
            k = LSJD_K_MOVE;
        end else if ((op & `LSJD_MASK_W) == `LSJD_OP_COMPARE) begin
            k = LSJD_K_COMPARE;
        end else if ((op & `LSJD_MASK_W) == `LSJD_OP_SCAN) begin
            k = LSJD_K_SCAN;
        end else if ((op & `LSJD_MASK_W) == `LSJD_OP_LOAD) begin
            k = LSJD_K_LOAD;
        end else if ((op & `LSJD_MASK_W) == `LSJD_OP_STORE) begin
            k = LSJD_K_STORE;
        end else if ((op & `LSJD_MASK_W) == `LSJD_OP_PORT_IN) begin
            k = LSJD_K_PORT_IN;
        end else if ((op & `LSJD_MASK_W) == `LSJD_OP_PORT_OUT) begin
            k = LSJD_K_PORT_OUT;
        end else if (op == `LSJD_OP_JMP_SHORT || op == `LSJD_OP_JMP_NEAR) begin
            k = LSJD_K_JMP;
        end
        return k;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    lsjd_state_t state_q, state_d; // Sequence state
    lsjd_kind_t kind_q, kind_d; // Kind being decoded
    logic word_q, word_d; // Word operand size
    logic dest_q, dest_d; // Register field is destination
    logic mem_q, mem_d; // Memory operand present
    logic rep_q, rep_d; // Repeat prefix seen
    logic repz_q, repz_d; // Prefix condition bit
    logic [1:0] tail_q, tail_d; // Trailing bytes still to take
    logic [COUNT_W-1:0] count_q, count_d; // Iteration count caught with the opcode
    logic [CYC_W-1:0] timer_q, timer_d; // Cycles left in execution
    logic ready_q, ready_d;
    logic valid_q, valid_d;
    logic unknown_q, unknown_d;
    logic done_q, done_d;
    logic busy_q, busy_d; // Execution under way, kept in a flop so the pin is glitch free
    logic [CYC_W-1:0] cyc_q, cyc_d;
    logic [CYC_W-1:0] cost; // Cost of the held instruction
    lsjd_kind_t cls; // Kind of the incoming byte
    logic take; // Byte accepted this cycle

    // ------------------------------------------------------------
    // Cost calculator
    // ------------------------------------------------------------
    lsjd_cost #(
        .COUNT_W(COUNT_W),
        .CYC_W(CYC_W)
    ) u_cost (
        .kind(kind_q),
        .word(word_q),
        .reg_is_dest(dest_q),
        .memory(mem_q),
        .repeated(rep_q),
        .narrow(NARROW_BUS),
        .count(count_q),
        .cycles(cost)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        cls = classify(BYTE_DATA);
        take = BYTE_VALID && ready_q;
        state_d = state_q;
        kind_d = kind_q;
        word_d = word_q;
        dest_d = dest_q;
        mem_d = mem_q;
        rep_d = rep_q;
        repz_d = repz_q;
        tail_d = tail_q;
        count_d = count_q;
        timer_d = timer_q;
        valid_d = 1'b0;
        unknown_d = 1'b0;
        done_d = 1'b0;
        cyc_d = cyc_q;
        case (state_q)
            LSJD_S_IDLE: begin
                if (take) begin
                    if ((BYTE_DATA & `LSJD_MASK_W) == `LSJD_OP_REPEAT) begin
                        // Prefix only arms the next opcode
                        rep_d = 1'b1;
                        repz_d = BYTE_DATA[`LSJD_BIT_Z];
                    end else begin
                        kind_d = cls;
                        word_d = BYTE_DATA[`LSJD_BIT_W];
                        dest_d = BYTE_DATA[`LSJD_BIT_D];
                        mem_d = 1'b0;
                        count_d = COUNT_REG;
                        // Prefix only has meaning ahead of a string primitive
                        if (cls == LSJD_K_XOR_RM || cls == LSJD_K_XOR_ACC ||
                            cls == LSJD_K_JMP) begin
                            rep_d = 1'b0;
                        end
                        if (cls == LSJD_K_XOR_RM) begin
                            state_d = LSJD_S_MODRM;
                        end else if (cls == LSJD_K_XOR_ACC) begin
                            tail_d = BYTE_DATA[`LSJD_BIT_W] ? `LSJD_TWO_BYTES
                                                            : `LSJD_ONE_BYTE;
                            state_d = LSJD_S_TAIL;
                        end else if (cls == LSJD_K_JMP) begin
                            tail_d = (BYTE_DATA == `LSJD_OP_JMP_SHORT) ? `LSJD_ONE_BYTE
                                                                       : `LSJD_TWO_BYTES;
                            state_d = LSJD_S_TAIL;
                        end else if (cls == LSJD_K_NONE) begin
                            // Outside this slice: flag it and drop any prefix
                            unknown_d = 1'b1;
                            rep_d = 1'b0;
                            repz_d = 1'b0;
                        end else begin
                            state_d = LSJD_S_COST;
                        end
                    end
                end
            end
            LSJD_S_MODRM: begin
                if (take) begin
                    mem_d = BYTE_DATA[`LSJD_MOD_HI:`LSJD_MOD_LO] != `LSJD_MOD_REG;
                    state_d = LSJD_S_COST;
                end
            end
            LSJD_S_TAIL: begin
                if (take) begin
                    tail_d = tail_q - `LSJD_ONE_BYTE;
                    if (tail_q == `LSJD_ONE_BYTE) begin
                        state_d = LSJD_S_COST;
                    end
                end
            end
            LSJD_S_COST: begin
                // Cost settles from held fields; publish it and start timing
                valid_d = 1'b1;
                cyc_d = cost;
                timer_d = cost;
                state_d = LSJD_S_EXEC;
            end
            default: begin
                // Execution: refuse bytes until the listed cycle count elapses
                timer_d = timer_q - CYC_W'(1);
                if (timer_q <= CYC_W'(1)) begin
                    done_d = 1'b1;
                    rep_d = 1'b0;
                    repz_d = 1'b0;
                    state_d = LSJD_S_IDLE;
                end
            end
        endcase
        ready_d = state_d == LSJD_S_IDLE || state_d == LSJD_S_MODRM ||
                  state_d == LSJD_S_TAIL;
        busy_d = state_d == LSJD_S_EXEC;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_q <= LSJD_S_IDLE;
            kind_q <= LSJD_K_NONE;
            word_q <= 1'b0;
            dest_q <= 1'b0;
            mem_q <= 1'b0;
            rep_q <= 1'b0;
            repz_q <= 1'b0;
            tail_q <= 2'h0;
            count_q <= '0;
            timer_q <= '0;
            ready_q <= 1'b0;
            valid_q <= 1'b0;
            unknown_q <= 1'b0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
            cyc_q <= '0;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            word_q <= word_d;
            dest_q <= dest_d;
            mem_q <= mem_d;
            rep_q <= rep_d;
            repz_q <= repz_d;
            tail_q <= tail_d;
            count_q <= count_d;
            timer_q <= timer_d;
            ready_q <= ready_d;
            valid_q <= valid_d;
            unknown_q <= unknown_d;
            done_q <= done_d;
            busy_q <= busy_d;
            cyc_q <= cyc_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign BYTE_READY = ready_q;
    assign OP_VALID = valid_q;
    assign OP_KIND = kind_q;
    assign OP_WORD = word_q;
    assign OP_REG_IS_DEST = dest_q;
    assign OP_MEMORY = mem_q;
    assign OP_REPEAT = rep_q;
    assign OP_REPEAT_COND = repz_q;
    assign OP_CYCLES = cyc_q;
    assign OP_UNKNOWN = unknown_q;
    assign EXEC_BUSY = busy_q;
    assign EXEC_DONE = done_q;

endmodule
`default_nettype wire

// ### lsjd_decoder_monitor.sv
// Port-level checker for the decoder, attached by bind
`timescale 1ns/1ps
`default_nettype none
module lsjd_decoder_monitor
    import lsjd_pkg::*;
#(
    parameter int COUNT_W = 16,
    parameter int CYC_W = 24
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic NARROW_BUS,
    input wire logic BYTE_READY,
    input wire logic OP_VALID,
    input wire lsjd_kind_t OP_KIND,
    input wire logic OP_WORD,
    input wire logic OP_REPEAT,
    input wire logic [CYC_W-1:0] OP_CYCLES,
    input wire logic OP_UNKNOWN,
    input wire logic EXEC_BUSY,
    input wire logic EXEC_DONE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    // ----
    // Execution countdown
    // ----
    logic [CYC_W-1:0] left_q; // Cycles still owed by the running op
    // Load at the decode strobe, then count down to one at the done pulse
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) left_q <= '0;
        else if (OP_VALID) left_q <= OP_CYCLES;
        else if (left_q != '0) left_q <= left_q - 1'b1;
    end
    // ----
    // Properties
    // ----
    property p_valid_pulse;
        OP_VALID |=> !OP_VALID;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("strobe over one cycle");
    property p_exec_start;
        OP_VALID |-> EXEC_BUSY && !BYTE_READY;
    endproperty
    a_exec_start: assert property (p_exec_start)
        else $error("no execution at strobe");
    property p_done_due;
        left_q == 8'h01 |-> EXEC_DONE;
    endproperty
    a_done_due: assert property (p_done_due)
        else $error("done missing");
    property p_done_only;
        EXEC_DONE |-> left_q == 8'h01 && !EXEC_BUSY ##1 !EXEC_DONE;
    endproperty
    a_done_only: assert property (p_done_only)
        else $error("done misplaced");
    property p_busy_refuse;
        EXEC_BUSY |-> !BYTE_READY;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse)
        else $error("byte ready while busy");
    property p_move_cost;
        OP_VALID && OP_KIND == LSJD_K_MOVE && !OP_REPEAT && !(OP_WORD && NARROW_BUS)
            |-> OP_CYCLES == 8'h0e;
    endproperty
    a_move_cost: assert property (p_move_cost)
        else $error("move cost");
    property p_jump_cost;
        OP_VALID && OP_KIND == LSJD_K_JMP |-> OP_CYCLES == 8'h0e && !OP_REPEAT;
    endproperty
    a_jump_cost: assert property (p_jump_cost)
        else $error("jump cost");
    property p_out_cost;
        OP_VALID && OP_KIND == LSJD_K_PORT_OUT && !OP_REPEAT |-> OP_CYCLES == 8'h0e;
    endproperty
    a_out_cost: assert property (p_out_cost)
        else $error("port output cost");
    property p_load_narrow;
        OP_VALID && OP_KIND == LSJD_K_LOAD && !OP_REPEAT && OP_WORD && NARROW_BUS
            |-> OP_CYCLES == 8'h10;
    endproperty
    a_load_narrow: assert property (p_load_narrow)
        else $error("narrow load cost");
    // Dropped opcodes never start execution
    property p_unknown;
        OP_UNKNOWN |-> !OP_VALID && !EXEC_BUSY ##1 !OP_UNKNOWN;
    endproperty
    a_unknown: assert property (p_unknown)
        else $error("unknown opcode ran");
    c_repeat: cover property (OP_VALID && OP_REPEAT);
    c_narrow: cover property (OP_VALID && OP_WORD && NARROW_BUS);
    c_unknown: cover property (OP_UNKNOWN);
endmodule
bind lsjd_decoder lsjd_decoder_monitor #(.COUNT_W(COUNT_W), .CYC_W(CYC_W)) u_mon (.*);
`default_nettype wire

// ### lsjd_byte_source.sv
// Instruction byte source standing in for the memory side of the fetch path
`timescale 1ns/1ps
`default_nettype none
module lsjd_byte_source (
    input wire logic clk,
    input wire logic rst,
    input wire logic ready,
    input wire logic slow,
    output logic valid,
    output logic [7:0] data
);
    logic [7:0] pend[$]; // Bytes queued by the bench
    logic live_q; // Keeps the first offer off the first edge after reset
    integer seed = 91; // Stall pattern seed
    task automatic push(input logic [7:0] b);
        pend.push_back(b);
    endtask
    // Offer head byte, hold it until taken; stall at random when slow
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            valid <= 1'b0;
            data <= 8'h00;
            live_q <= 1'b0;
        end else begin
            live_q <= 1'b1;
            if (valid && ready) begin
                pend.delete(0);
            end
            if (!valid || ready) begin
                if (live_q && pend.size() > 0 && !(slow && ($random(seed) & 1))) begin
                    valid <= 1'b1;
                    data <= pend[0];
                end else begin
                    // Idle bus must not look like the last byte
                    valid <= 1'b0;
                    data <= ~data;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### tb_logic_string_jump_decoder.sv
// Self-checking bench for the decoder fed by the byte source
`timescale 1ns/1ps
`default_nettype none
module tb_logic_string_jump_decoder
    import lsjd_pkg::*;
;
    logic SYS_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic NARROW_BUS = 1'b0;
    logic [15:0] COUNT_REG = 16'h0000;
    logic slow = 1'b0;
    logic BYTE_VALID, BYTE_READY, OP_VALID, OP_WORD, OP_REG_IS_DEST, OP_MEMORY;
    logic OP_REPEAT, OP_REPEAT_COND, OP_UNKNOWN, EXEC_BUSY, EXEC_DONE;
    logic [7:0] BYTE_DATA;
    logic [23:0] OP_CYCLES;
    lsjd_kind_t OP_KIND;
    int mismatches = 0, checked = 0, tnum = 0;
    integer seed = 58;
    always #20 SYS_CLK = ~SYS_CLK;
    lsjd_decoder uut (.*);
    lsjd_byte_source src (.clk(SYS_CLK), .rst(SYS_RST), .ready(BYTE_READY), .slow(slow),
        .valid(BYTE_VALID), .data(BYTE_DATA));
    // ----
    // Reporting
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            mismatches++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ----
    // Reference decode and cost
    // ----
    function automatic lsjd_kind_t kind_of(input logic [7:0] op);
        casez (op)
            8'b001100??: return LSJD_K_XOR_RM;
            8'b0011010?: return LSJD_K_XOR_ACC;
            8'b1010010?: return LSJD_K_MOVE;
            8'b1010011?: return LSJD_K_COMPARE;
            8'b1010111?: return LSJD_K_SCAN;
            8'b1010110?: return LSJD_K_LOAD;
            8'b1010101?: return LSJD_K_STORE;
            8'b0110110?: return LSJD_K_PORT_IN;
            8'b0110111?: return LSJD_K_PORT_OUT;
            8'heb, 8'he9: return LSJD_K_JMP;
            default: return LSJD_K_NONE;
        endcase
    endfunction
    // Single s+p*ts, repeated b+n*(it+p*tr), p the narrow word penalty
    function automatic logic [23:0] exp_cyc(input lsjd_kind_t k, input logic [7:0] op,
            input logic mem, input logic repeat_prefix, input logic nar, input logic [15:0] n);
        int s, b, it, ts, tr, p;
        s = 8'h0e; b = 8'h08; it = 8'h08; ts = 8'h00; tr = 8'h01;
        case (k)
            LSJD_K_XOR_RM: begin s = mem ? 8'h0a : 8'h03; ts = mem ? 8'h02 - op[1] : 8'h00; end
            LSJD_K_XOR_ACC: s = 8'h03 + op[0];
            LSJD_K_MOVE: begin ts = 8'h02; tr = 8'h02; end
            LSJD_K_COMPARE: begin s = 8'h16; b = 8'h05; it = 8'h16; ts = 8'h02; tr = 8'h00; end
            LSJD_K_SCAN: begin s = 8'h0f; b = 8'h05; it = 8'h0f; ts = 8'h01; end
            LSJD_K_LOAD: begin s = 8'h0c; b = 8'h06; it = 8'h0b; ts = 8'h01; end
            LSJD_K_STORE: begin s = 8'h0a; b = 8'h06; it = 8'h09; ts = 8'h01; end
            default: ;
        endcase
        p = (nar && op[0]) ? 8'h04 : 8'h00;
        return repeat_prefix ? 24'(b + n * (it + p * tr)) : 24'(s + p * ts);
    endfunction
    function automatic logic [7:0] pick(input logic [31:0] r);
        logic [7:0] ops [12];
        int idx;
        ops = '{8'h30, 8'h34, 8'ha4, 8'ha6, 8'hae, 8'hac, 8'haa, 8'h6c, 8'h6e, 8'heb, 8'he9, 8'hf4};
        idx = r[31:16] % 12;
        return ops[idx] | {6'h00, idx == 0 ? r[1:0] : {1'b0, r[0] & (idx < 9)}};
    endfunction
    // ----
    // One instruction: feed, check decode, time execution
    // ----
    task automatic run_op(input logic [7:0] op, input logic [1:0] pre, input logic [15:0] n,
            input logic nar);
        lsjd_kind_t k;
        logic [7:0] m;
        logic mem, repeat_prefix;
        int i, nb;
        logic [23:0] want;
        k = kind_of(op);
        m = $random(seed);
        mem = m[7:6] != 2'h3;
        repeat_prefix = k >= LSJD_K_MOVE && k <= LSJD_K_PORT_OUT && pre != 2'h0;
        nb = int'(k == LSJD_K_XOR_RM) + int'(k == LSJD_K_XOR_ACC) * (1 + op[0]);
        nb = nb + int'(op == 8'heb) + 2 * int'(op == 8'he9);
        want = exp_cyc(k, op, mem, repeat_prefix, nar, n);
        @(posedge SYS_CLK);
        COUNT_REG <= n;
        NARROW_BUS <= nar;
        slow <= m[0];
        #1;
        if (pre != 2'h0) src.push({6'h3c, pre});
        src.push(op);
        for (i = 0; i < nb; i++) src.push(m ^ 8'(i));
        for (i = 0; i < 400 && OP_VALID !== 1'b1 && OP_UNKNOWN !== 1'b1; i++) begin
            @(posedge SYS_CLK);
            #1;
        end
        if (i == 400) begin
            mismatches++;
            tally_and_finish();
        end
        if (k == LSJD_K_NONE) begin
            check({OP_UNKNOWN, OP_VALID}, 2'h2);
        end else begin
            check(OP_KIND, k);
            check(OP_CYCLES, want);
            check(OP_REPEAT, repeat_prefix);
            if (repeat_prefix) check(OP_REPEAT_COND, pre[0]);
            if (k != LSJD_K_JMP) check(OP_WORD, op[0]);
            if (k == LSJD_K_XOR_RM) check({OP_REG_IS_DEST, OP_MEMORY}, {op[1], mem});
            for (i = 0; i < 5000 && EXEC_DONE !== 1'b1; i++) begin
                @(posedge SYS_CLK);
                #1;
            end
            if (i == 5000) begin
                mismatches++;
                tally_and_finish();
            end
            check(i, want);
        end
        $display("test %0d opcode %h done", tnum, op);
        tnum++;
    endtask
    // ----
    // Main sequence: corner cases, then random ones
    // ----
    initial begin
        logic [31:0] r;
        int t;
        repeat (5) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        run_op(8'ha5, 2'h2, 16'h0000, 1'b1);
        run_op(8'ha4, 2'h2, 16'h0100, 1'b0);
        run_op(8'ha7, 2'h3, 16'h0003, 1'b1);
        run_op(8'h6f, 2'h0, 16'h0000, 1'b1);
        run_op(8'had, 2'h0, 16'h0000, 1'b1);
        run_op(8'heb, 2'h2, 16'h0005, 1'b1);
        run_op(8'h33, 2'h0, 16'h0000, 1'b1);
        run_op(8'hf4, 2'h0, 16'h0000, 1'b0);
        for (t = 0; t < 80; t++) begin
            r = $random(seed);
            run_op(pick(r), r[5] ? {1'b1, r[6]} : 2'h0, {13'h0000, r[10:8]}, r[11]);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
